// ---- linear_pixel_array_readout.sv ----
/*
 * array end: readout sequencing of both sections of the linear array.
 * each section has a start shift register, an integrator reset timer
 * and a pixel output stage enabled only during its output phase.
 * assumes all link pins are asynchronous to sys_clk_i and change no
 * faster than once per eight system clocks; the user side supplies the
 * held level of the pixel named on pixel_index_o in the same cycle.
 */
`timescale 1ns/100ps
`default_nettype none

// Contract
// - each section: 640-stage shift register plus reset
// - readout starts when start sampled high
// - freeze rising edge holds samples, starts reset
// - shifting pulse outputs one pixel per clock
// - integrator reset ends 18 clocks after start
// - chain output a rises on 640th edge
// - 641st edge ends chain a, output off
// - chain b on 1280th, 1281st ends it
// - next start waits transfer time after 1281st
// - serial mode: chain a drives start b
// - chain b starts cascade or marks end
// - serial: freeze a tied to start a, freeze b
// - parallel: each freeze tied to own start
// - pixel output high impedance outside output phase
// - controller allows 20 us charge transfer
// - start low again before next rising edge
module linear_pixel_array_readout (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// link to the controller
	sensor_link_if.array link,
	// held pixel levels, one per section
	input wire logic [lpa_pkg::SECTIONS-1:0][lpa_pkg::PIX_W-1:0] light_level_i,
	// pixel being read out, per section
	output logic [lpa_pkg::SECTIONS-1:0][lpa_pkg::IDX_W-1:0] pixel_index_o,
	// integration running, per section
	output logic [lpa_pkg::SECTIONS-1:0] integrating_o,
	// sampling capacitors held, per section
	output logic [lpa_pkg::SECTIONS-1:0] samples_held_o
);
	import lpa_pkg::*;

	// pin groups gathered per section
	wire [SECTIONS-1:0] clk_pin;
	wire [SECTIONS-1:0] start_pin;
	wire [SECTIONS-1:0] freeze_pin;
	// per-section results before they reach the pins
	logic [SECTIONS-1:0] chain_q;
	logic [SECTIONS-1:0] drive_q;
	logic [SECTIONS-1:0][PIX_W-1:0] level_q;

	assign clk_pin = {link.section_clock_b, link.section_clock_a};
	assign start_pin = {link.scan_start_in_b, link.scan_start_in_a};
	assign freeze_pin = {link.sample_freeze_b, link.sample_freeze_a};

	// pins driven straight from the section flops
	assign link.chain_out_a = chain_q[0];
	assign link.chain_out_b = chain_q[1];
	assign link.pixel_voltage_out_a = level_q[0];
	assign link.pixel_voltage_out_b = level_q[1];
	assign link.pixel_voltage_out_a_oe = drive_q[0];
	assign link.pixel_voltage_out_b_oe = drive_q[1];

	// one copy of the sequencer per section
	genvar g;
	generate
		for (g = 0; g < SECTIONS; g++)
		begin : sec
			// two-flop synchronisers for the three pins
			logic [1:0] clk_s_q;
			logic [1:0] start_s_q;
			logic [1:0] freeze_s_q;
			// previous synchronised levels, for edges
			logic clk_prev_q;
			logic freeze_prev_q;
			// start pulse travelling through the pixels
			logic [PIXELS_PER_SECTION-1:0] shift_q;
			logic [PIXELS_PER_SECTION-1:0] shift_d;
			// integrator reset: armed by freeze, timed from start
			logic reset_arm_q;
			logic reset_arm_d;
			logic [4:0] reset_cnt_q;
			logic [4:0] reset_cnt_d;
			// samples disconnected from the integrators
			logic held_q;
			logic held_d;
			// pixel position of the travelling pulse
			logic [IDX_W-1:0] index_q;
			logic [IDX_W-1:0] index_d;

			// decoded events
			wire clk_rise;
			wire freeze_rise;
			wire start_taken;
			wire in_output;
			wire reset_busy_d;
			wire pulse_leaves; // last stage emptied on this edge

			// section clock and freeze edges on the synchronised levels
			assign clk_rise = clk_s_q[1] & ~clk_prev_q;
			assign freeze_rise = freeze_s_q[1] & ~freeze_prev_q;
			// start seen high on a section clock rising edge
			assign start_taken = clk_rise & start_s_q[1];

			// pulse shifts one pixel per section clock edge
			assign shift_d = clk_rise ? {shift_q[PIXELS_PER_SECTION-2:0], start_s_q[1]} : shift_q;
			// output phase lasts while the pulse is inside
			assign in_output = |shift_d;

			// pixel index: pixel 0 after the start edge, then one per edge
			assign index_d = start_taken ? '0 : (clk_rise && in_output) ? index_q + 10'h001 : index_q;

			// freeze edge starts the reset at once, start edge times it
			assign reset_arm_d = freeze_rise ? 1'b1 : clk_rise ? 1'b0 : reset_arm_q;
			assign reset_cnt_d = start_taken ? INTEG_RESET_CLOCKS :
				(clk_rise && reset_cnt_q != 5'h00) ? reset_cnt_q - 5'h01 : reset_cnt_q;
			assign reset_busy_d = reset_arm_d | (reset_cnt_d != 5'h00);

			// samples held from the freeze edge until the pulse leaves
			// a chained section stays held while it waits for its own pulse
			assign pulse_leaves = clk_rise & (|shift_q) & ~in_output;
			assign held_d = freeze_rise ? 1'b1 : pulse_leaves ? 1'b0 : held_q;

			// pin synchronisers; only the second stage is read
			always_ff @(posedge sys_clk_i or posedge rst_i)
			begin
				if (rst_i)
				begin
					clk_s_q <= 2'h0;
					start_s_q <= 2'h0;
					freeze_s_q <= 2'h0;
				end
				else
				begin
					clk_s_q <= {clk_s_q[0], clk_pin[g]};
					start_s_q <= {start_s_q[0], start_pin[g]};
					freeze_s_q <= {freeze_s_q[0], freeze_pin[g]};
				end
			end

			// edge history
			always_ff @(posedge sys_clk_i or posedge rst_i)
			begin
				if (rst_i)
				begin
					clk_prev_q <= 1'b0;
					freeze_prev_q <= 1'b0;
				end
				else
				begin
					clk_prev_q <= clk_s_q[1];
					freeze_prev_q <= freeze_s_q[1];
				end
			end

			// shift register and pixel position
			always_ff @(posedge sys_clk_i or posedge rst_i)
			begin
				if (rst_i)
				begin
					shift_q <= '0;
					index_q <= '0;
				end
				else
				begin
					shift_q <= shift_d;
					index_q <= index_d;
				end
			end

			// integrator reset timing and sample hold
			always_ff @(posedge sys_clk_i or posedge rst_i)
			begin
				if (rst_i)
				begin
					reset_arm_q <= 1'b0;
					reset_cnt_q <= 5'h00;
					held_q <= 1'b0;
				end
				else
				begin
					reset_arm_q <= reset_arm_d;
					reset_cnt_q <= reset_cnt_d;
					held_q <= held_d;
				end
			end

			// pins: chain pulse in the last stage, pixel level while shifting
			always_ff @(posedge sys_clk_i or posedge rst_i)
			begin
				if (rst_i)
				begin
					chain_q[g] <= 1'b0;
					drive_q[g] <= 1'b0;
					level_q[g] <= '0;
				end
				else
				begin
					// last stage: 640th edge raises, 641st drops
					chain_q[g] <= shift_d[PIXELS_PER_SECTION-1];
					// output stage off outside the output phase
					drive_q[g] <= in_output;
					level_q[g] <= in_output ? light_level_i[g] : '0;
				end
			end

			// user side status
			always_ff @(posedge sys_clk_i or posedge rst_i)
			begin
				if (rst_i)
				begin
					pixel_index_o[g] <= '0;
					integrating_o[g] <= 1'b1;
					samples_held_o[g] <= 1'b0;
				end
				else
				begin
					pixel_index_o[g] <= index_d;
					// next integration starts as soon as the reset ends
					integrating_o[g] <= ~reset_busy_d;
					samples_held_o[g] <= held_d;
				end
			end
		end
	endgenerate

endmodule : linear_pixel_array_readout

`default_nettype wire

// ---- lpa_pkg.sv ----
/*
 * shared constants for the two-section linear pixel array readout:
 * section geometry, readout edge counts, link clock divider and the
 * charge transfer delay.
 * assumes a 100 MHz system clock at both ends of the link.
 */
package lpa_pkg;

	// array geometry
	localparam int SECTIONS = 2;
	localparam int PIXELS_PER_SECTION = 640;
	localparam int PIX_W = 8;
	localparam int IDX_W = 10;
	localparam int EDGE_W = 11;

	// sequencing figures, in section clock rising edges
	localparam logic [4:0] INTEG_RESET_CLOCKS = 5'h12;
	localparam logic [EDGE_W-1:0] END_EDGE_PARALLEL = 11'h281;
	localparam logic [EDGE_W-1:0] END_EDGE_SERIAL = 11'h501;

	// system clock and section clock divider
	localparam int SYS_CLK_MHZ = 100;
	localparam logic [3:0] CLK_HALF_CYCLES = 4'h8;

	// charge transfer delay after the last clock, least time
	localparam int CHARGE_TRANSFER_DELAY_US = 20;
	localparam int CHARGE_TRANSFER_CYCLES = CHARGE_TRANSFER_DELAY_US * SYS_CLK_MHZ;
	localparam int WAIT_W = 12;

	// controller sequencer states
	typedef enum logic [1:0] {
		CTRL_IDLE,
		CTRL_RUN,
		CTRL_SETTLE
	} ctrl_state_e;

endpackage : lpa_pkg

// ---- sensor_link_if.sv ----
/*
 * pins between the linear array and its controller.
 * assumes the testbench resolves each analog output to high impedance
 * from its output enable; no clocking block here.
 */
`timescale 1ns/100ps
`default_nettype none

interface sensor_link_if;
	import lpa_pkg::*;

	// section clocks, made by the controller
	logic section_clock_a;
	logic section_clock_b;
	// start and freeze inputs of the array
	logic scan_start_in_a;
	logic scan_start_in_b;
	logic sample_freeze_a;
	logic sample_freeze_b;
	// chained start pulses out of the array
	logic chain_out_a;
	logic chain_out_b;
	// pixel outputs, high impedance while the enable is low
	logic [PIX_W-1:0] pixel_voltage_out_a;
	logic [PIX_W-1:0] pixel_voltage_out_b;
	logic pixel_voltage_out_a_oe;
	logic pixel_voltage_out_b_oe;

	// the array end
	modport array (
		input section_clock_a, section_clock_b,
		input scan_start_in_a, scan_start_in_b,
		input sample_freeze_a, sample_freeze_b,
		output chain_out_a, chain_out_b,
		output pixel_voltage_out_a, pixel_voltage_out_b,
		output pixel_voltage_out_a_oe, pixel_voltage_out_b_oe
	);

	// the controller end
	modport ctrl (
		output section_clock_a, section_clock_b,
		output scan_start_in_a, scan_start_in_b,
		output sample_freeze_a, sample_freeze_b,
		input chain_out_a, chain_out_b,
		input pixel_voltage_out_a, pixel_voltage_out_b,
		input pixel_voltage_out_a_oe, pixel_voltage_out_b_oe
	);

endinterface : sensor_link_if

`default_nettype wire

// ---- linear_array_controller.sv ----
/*
 * controller end: makes the section clocks, start and freeze pulses for
 * one frame in serial or parallel mode and captures the pixel levels.
 * assumes the array end of sensor_link_if and a 100 MHz system clock.
 */
`timescale 1ns/100ps
`default_nettype none

module linear_array_controller (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// link to the array
	sensor_link_if.ctrl link,
	// frame request
	input wire logic serial_mode_i,
	input wire logic frame_req_i,
	// frame status
	output logic busy_o,
	output logic frame_done_o,
	// captured pixels, per section
	output logic [lpa_pkg::SECTIONS-1:0][lpa_pkg::PIX_W-1:0] pixel_data_o,
	output logic [lpa_pkg::SECTIONS-1:0] pixel_valid_o
);
	import lpa_pkg::*;

	ctrl_state_e state_q;
	logic serial_q; // mode latched per frame
	logic [3:0] div_q; // system cycles within a clock half
	logic sclk_q; // common section clock
	logic [EDGE_W-1:0] edges_q; // rising edges made this frame
	logic [WAIT_W-1:0] wait_q; // transfer delay counter
	logic start_a_q;
	logic start_b_q;
	logic freeze_a_q;
	logic freeze_b_q;
	// synchronisers for the array outputs
	logic [1:0] chain_a_s_q;
	logic [1:0] oe_a_s_q;
	logic [1:0] oe_b_s_q;
	logic [1:0][PIX_W-1:0] lvl_a_s_q;
	logic [1:0][PIX_W-1:0] lvl_b_s_q;

	// decoded timing
	wire half_end = (div_q == CLK_HALF_CYCLES - 4'h1);
	wire rise_now = (state_q == CTRL_RUN) && half_end && !sclk_q;
	wire fall_now = (state_q == CTRL_RUN) && half_end && sclk_q;
	wire [EDGE_W-1:0] end_edge = serial_q ? END_EDGE_SERIAL : END_EDGE_PARALLEL;
	wire frame_start = (state_q == CTRL_IDLE) && frame_req_i;
	// mode of this frame, taken from serial_mode_i on the start cycle
	wire ser_now = frame_start ? serial_mode_i : serial_q;
	wire run_end = fall_now && (edges_q == end_edge);
	wire settle_end = (state_q == CTRL_SETTLE) && (wait_q == WAIT_W'(CHARGE_TRANSFER_CYCLES - 1));
	// start high for the first rising edge only
	wire start_a_d = frame_start ? 1'b1 : fall_now ? 1'b0 : start_a_q;
	// serial: chain a feeds start b; parallel: both start together
	wire start_b_d = ser_now ? chain_a_s_q[1] :
		frame_start ? 1'b1 : fall_now ? 1'b0 : start_b_q;

	assign link.section_clock_a = sclk_q;
	assign link.section_clock_b = sclk_q;
	assign link.scan_start_in_a = start_a_q;
	assign link.scan_start_in_b = start_b_q;
	assign link.sample_freeze_a = freeze_a_q;
	assign link.sample_freeze_b = freeze_b_q;

	// sequencer: idle, clocking, charge transfer wait
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			state_q <= CTRL_IDLE;
		else
			case (state_q)
				CTRL_IDLE: state_q <= frame_req_i ? CTRL_RUN : CTRL_IDLE;
				CTRL_RUN: state_q <= run_end ? CTRL_SETTLE : CTRL_RUN;
				CTRL_SETTLE: state_q <= settle_end ? CTRL_IDLE : CTRL_SETTLE;
				default: state_q <= CTRL_IDLE;
			endcase
	end

	// clock divider and edge count
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			div_q <= 4'h0;
			sclk_q <= 1'b0;
			edges_q <= '0;
			serial_q <= 1'b0;
		end
		else
		begin
			div_q <= (state_q != CTRL_RUN || half_end) ? 4'h0 : div_q + 4'h1;
			// toggles each half period, holds between, low outside frames
			sclk_q <= (state_q != CTRL_RUN) ? 1'b0 : half_end ? ~sclk_q : sclk_q;
			edges_q <= frame_start ? '0 : rise_now ? edges_q + 11'h001 : edges_q;
			serial_q <= frame_start ? serial_mode_i : serial_q;
		end
	end

	// transfer wait counter
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			wait_q <= '0;
		else
			wait_q <= (state_q == CTRL_SETTLE) ? wait_q + 12'h001 : '0;
	end

	// start and freeze pins
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			start_a_q <= 1'b0;
			start_b_q <= 1'b0;
			freeze_a_q <= 1'b0;
			freeze_b_q <= 1'b0;
		end
		else
		begin
			start_a_q <= start_a_d;
			start_b_q <= start_b_d;
			freeze_a_q <= start_a_d;
			freeze_b_q <= ser_now ? start_a_d : start_b_d;
		end
	end

	// synchronisers on the array outputs
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			chain_a_s_q <= 2'h0;
			oe_a_s_q <= 2'h0;
			oe_b_s_q <= 2'h0;
			lvl_a_s_q <= '0;
			lvl_b_s_q <= '0;
		end
		else
		begin
			chain_a_s_q <= {chain_a_s_q[0], link.chain_out_a};
			oe_a_s_q <= {oe_a_s_q[0], link.pixel_voltage_out_a_oe};
			oe_b_s_q <= {oe_b_s_q[0], link.pixel_voltage_out_b_oe};
			lvl_a_s_q <= {lvl_a_s_q[0], link.pixel_voltage_out_a};
			lvl_b_s_q <= {lvl_b_s_q[0], link.pixel_voltage_out_b};
		end
	end

	// pixel capture at each falling edge while that section's output enable is high, mid pixel
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			pixel_valid_o <= '0;
			pixel_data_o <= '0;
			busy_o <= 1'b0;
			frame_done_o <= 1'b0;
		end
		else
		begin
			pixel_valid_o <= {fall_now & oe_b_s_q[1], fall_now & oe_a_s_q[1]};
			pixel_data_o[0] <= (fall_now && oe_a_s_q[1]) ? lvl_a_s_q[1] : pixel_data_o[0];
			pixel_data_o[1] <= (fall_now && oe_b_s_q[1]) ? lvl_b_s_q[1] : pixel_data_o[1];
			busy_o <= frame_start | (state_q == CTRL_RUN) | (state_q == CTRL_SETTLE && !settle_end);
			frame_done_o <= settle_end;
		end
	end

endmodule : linear_array_controller

`default_nettype wire

// ---- lpa_link_assertions.sv ----
/*
 * link checker: watches the pins between the array end and the controller.
 * assumes it is instantiated beside the interface, one 100 MHz clock.
 */
`timescale 1ns/100ps
`default_nettype none

module lpa_link_assertions (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// controller to array
	input wire logic section_clock_a,
	input wire logic section_clock_b,
	input wire logic scan_start_in_a,
	input wire logic sample_freeze_a,
	// array to controller
	input wire logic chain_out_a,
	input wire logic chain_out_b,
	input wire logic pixel_voltage_out_a_oe,
	input wire logic pixel_voltage_out_b_oe
);
	// one clock domain for every property
	default clocking dclk @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);

	a_chain_a_width: assert property (
		$rose(chain_out_a) |-> chain_out_a[*8] ##1 chain_out_a[*8] ##1 !chain_out_a)
		else $error("chain a pulse width wrong");
	a_chain_b_width: assert property (
		$rose(chain_out_b) |-> chain_out_b[*8] ##1 chain_out_b[*8] ##1 !chain_out_b)
		else $error("chain b pulse width wrong");
	a_oe_a_release: assert property (
		$fell(chain_out_a) |-> !pixel_voltage_out_a_oe)
		else $error("output a still driven after chain a");
	a_oe_b_release: assert property (
		$fell(chain_out_b) |-> !pixel_voltage_out_b_oe)
		else $error("output b still driven after chain b");
	a_chain_in_output: assert property (
		$rose(chain_out_a) |-> pixel_voltage_out_a_oe)
		else $error("chain a outside output phase");
	a_start_opens_a: assert property (
		$rose(scan_start_in_a) |-> ##[4:20] pixel_voltage_out_a_oe)
		else $error("output a not opened after start");
	a_start_one_edge: assert property (
		$rose(scan_start_in_a) |-> ##[1:20] !scan_start_in_a)
		else $error("start held too long");
	a_freeze_tied_a: assert property (
		sample_freeze_a == scan_start_in_a)
		else $error("freeze a differs from start a");
	a_common_clock: assert property (
		section_clock_a == section_clock_b)
		else $error("section clocks differ");
	a_clock_half: assert property (
		$rose(section_clock_a) |-> section_clock_a[*8] ##1 !section_clock_a)
		else $error("section clock high time wrong");

	// main scenarios reached
	c_chain_a: cover property ($rose(chain_out_a));
	c_chain_b: cover property ($rose(chain_out_b));
	c_oe_b_off: cover property ($fell(pixel_voltage_out_b_oe));

endmodule : lpa_link_assertions

`default_nettype wire

// ---- tb_top.sv ----
/*
 * testbench: array end and controller joined by the link interface;
 * runs parallel, serial and refused-request frames.
 * assumes a 100 MHz clock and the package constants.
 */
`timescale 1ns/100ps
`default_nettype none

module tb_top;
	import lpa_pkg::*;

	logic sys_clk_i, rst_i, serial_mode_i, frame_req_i; // bench driven
	wire logic busy_o, frame_done_o; // frame status
	wire logic [SECTIONS-1:0][PIX_W-1:0] lvl, pd; // levels, captured data
	wire logic [SECTIONS-1:0][IDX_W-1:0] idx; // pixel in output
	wire logic [SECTIONS-1:0] pv, integ, held; // valid, integrating, samples held
	logic [1:0] held_at_chain; // held flags seen as each chain pulse rises
	wire logic [PIX_W-1:0] ao_a, ao_b; // resolved pixel pins
	int errors, n_tests, ecount, ea, eb, eb_start, eint, quiet;
	int cnt [2];
	logic p_clk, p_sa, p_sb, p_ca, p_cb, p_int; // previous samples

	sensor_link_if link();

	// pixel level pattern per section
	function automatic logic [7:0] pix(input int s, input int k);
		pix = k[7:0] ^ (s != 0 ? 8'h5a : 8'ha5);
	endfunction : pix

	assign lvl[0] = pix(0, int'(idx[0]));
	assign lvl[1] = pix(1, int'(idx[1]));
	// high impedance while not enabled
	assign ao_a = link.pixel_voltage_out_a_oe ? link.pixel_voltage_out_a : 8'hzz;
	assign ao_b = link.pixel_voltage_out_b_oe ? link.pixel_voltage_out_b : 8'hzz;

	linear_pixel_array_readout i_linear_pixel_array_readout (.sys_clk_i, .rst_i,
		.link(link), .light_level_i(lvl), .pixel_index_o(idx), .integrating_o(integ),
		.samples_held_o(held));
	linear_array_controller i_linear_array_controller (.sys_clk_i, .rst_i, .link(link),
		.serial_mode_i, .frame_req_i, .busy_o, .frame_done_o, .pixel_data_o(pd),
		.pixel_valid_o(pv));
	lpa_link_assertions i_lpa_link_assertions (.sys_clk_i, .rst_i,
		.section_clock_a(link.section_clock_a), .section_clock_b(link.section_clock_b),
		.scan_start_in_a(link.scan_start_in_a), .sample_freeze_a(link.sample_freeze_a),
		.chain_out_a(link.chain_out_a), .chain_out_b(link.chain_out_b),
		.pixel_voltage_out_a_oe(link.pixel_voltage_out_a_oe),
		.pixel_voltage_out_b_oe(link.pixel_voltage_out_b_oe));

	// compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// verdict and end of run
	task automatic results();
		$display("errors=%0d n_tests=%0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : results

	// wire monitor: edge counts and pixel data, sampled mid cycle
	always @(negedge sys_clk_i)
	begin
		if (link.section_clock_a && !p_clk)
		begin
			ecount++;
			quiet = 0;
		end
		else
			quiet++;
		if (link.scan_start_in_a && !p_sa)
			ecount = 0;
		if (link.scan_start_in_b && !p_sb)
			eb_start = ecount;
		if (link.chain_out_a && !p_ca)
		begin
			ea = ecount;
			held_at_chain[0] = held[0];
		end
		if (link.chain_out_b && !p_cb)
		begin
			eb = ecount;
			held_at_chain[1] = held[1];
		end
		if (integ[0] && !p_int)
			eint = ecount;
		for (int s = 0; s < 2; s++)
			if (pv[s] === 1'b1)
			begin
				check({24'h0, pd[s]}, {24'h0, pix(s, cnt[s])});
				cnt[s]++;
			end
		{p_clk, p_sa, p_sb} = {link.section_clock_a, link.scan_start_in_a, link.scan_start_in_b};
		{p_ca, p_cb, p_int} = {link.chain_out_a, link.chain_out_b, integ[0]};
	end

	// one frame, optionally with a request while busy
	task automatic run_frame(input logic ser, input bit poke);
		cnt[0] = 0;
		cnt[1] = 0;
		held_at_chain = 2'h0;
		serial_mode_i <= ser;
		frame_req_i <= 1'b1;
		@(posedge sys_clk_i);
		frame_req_i <= 1'b0;
		if (poke)
		begin
			repeat (100) @(posedge sys_clk_i);
			frame_req_i <= 1'b1;
			@(posedge sys_clk_i);
			frame_req_i <= 1'b0;
			@(negedge sys_clk_i);
			check(busy_o, 1);
		end
		for (int i = 0; i <= 40000; i++)
		begin
			@(negedge sys_clk_i);
			if (frame_done_o === 1'b1)
				break;
			if (i == 40000)
			begin
				errors++;
				results();
			end
		end
		check(cnt[0], 640);
		check(cnt[1], 640);
		check(ea, 640);
		check(eint, INTEG_RESET_CLOCKS + 1);
		check(quiet >= CHARGE_TRANSFER_CYCLES, 1);
		check({24'h0, ao_a}, 32'h000000zz);
		check({24'h0, ao_b}, 32'h000000zz);
		check(held_at_chain, 2'h3);
		check(held, 2'h0);
		// back onto the rising edge for the next request
		@(posedge sys_clk_i);
	endtask : run_frame

	// both sections started together
	task automatic test_parallel();
		run_frame(1'b0, 0);
		check(eb_start, 0);
		check(eb, 640);
		check(ecount, END_EDGE_PARALLEL);
		$display("test_parallel done");
	endtask : test_parallel

	// section b chained from section a
	task automatic test_serial();
		run_frame(1'b1, 0);
		check(eb_start, 640);
		check(eb, 1280);
		check(ecount, END_EDGE_SERIAL);
		$display("test_serial done");
	endtask : test_serial

	// request while busy is dropped, no second frame
	task automatic test_refuse();
		run_frame(1'b0, 1);
		repeat (200) @(posedge sys_clk_i);
		@(negedge sys_clk_i);
		check(busy_o, 0);
		$display("test_refuse done");
	endtask : test_refuse

	// clock
	initial
	begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end

	// main sequence
	initial
	begin
		{rst_i, serial_mode_i, frame_req_i} = 3'b100;
		{errors, n_tests, ecount, ea, eb, eb_start, eint, quiet} = '0;
		{p_clk, p_sa, p_sb, p_ca, p_cb, p_int} = '0;
		repeat (6) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		@(posedge sys_clk_i);
		test_parallel();
		test_serial();
		test_refuse();
		results();
	end

endmodule : tb_top

`default_nettype wire
